// file: bus_hold_cs.sv
// local bus sequencer with bus hand-over and chip-select outputs
// assumes core-side request and configuration inputs on core_clk_i;
// the takeover request pin is asynchronous
`timescale 1ns/1ns
`include "bus_hold_defs.svh"
module bus_hold_cs
    import bus_hold_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // core cycle requests
    input wire logic cycle_req_i,
    input wire logic [`ADDR_W-1:0] cycle_addr_i,
    input wire logic [`DATA_W-1:0] cycle_wdata_i,
    input wire logic cycle_mem_i,
    input wire logic cycle_write_i,
    input wire logic cycle_fetch_i,
    output logic cycle_accept_o,
    output logic cycle_done_o,
    // select range configuration
    input wire logic [7:0] upper_start_i,
    input wire logic [7:0] lower_last_i,
    input wire logic [6:0] mid_base_i,
    input wire logic [2:0] mid_size_sel_i,
    input wire logic [5:0] periph_base_i,
    input wire logic periph_in_mem_i,
    input wire logic sixth_is_addr1_i,
    // bus takeover
    input wire logic bus_takeover_req_i,
    output logic bus_takeover_grant_o,
    // cycle status lines
    output logic cycle_status_bit2_o,
    output logic cycle_status_bit1_o,
    output logic cycle_status_bit0_o,
    output logic cycle_status_oe_o,
    // address/data bus
    output logic [`DATA_W-1:0] ad_o,
    output logic [3:0] addr_hi_o,
    output logic ad_oe_o,
    // control lines
    output logic addr_latch_o,
    output logic rd_n_o,
    output logic wr_n_o,
    output logic xcvr_direction_o,
    output logic ctrl_oe_o,
    // selects
    output logic upper_mem_select_n_o,
    output logic lower_mem_select_n_o,
    output logic [`MID_COUNT-1:0] mid_mem_selects_n_o,
    output logic [`PERIPH_COUNT-2:0] periph_selects_n_o,
    output logic sixth_select_or_addr_bit1_o
);
    localparam int SEL_W = 2 + `MID_COUNT + `PERIPH_COUNT;

    // elaboration-time checks: the decoder and pin slices assume these sizes
    generate
        if (`ADDR_W != 20) begin : g_bad_addr_w
            $error("address width must be 20");
        end
        if (`DATA_W != 16) begin : g_bad_data_w
            $error("data width must be 16");
        end
        if (`MID_COUNT != 4) begin : g_bad_mid_count
            $error("mid-range select count must be 4");
        end
        if (`PERIPH_COUNT != 6) begin : g_bad_periph_count
            $error("peripheral select count must be 6");
        end
        if (SEL_W != 12) begin : g_bad_sel_w
            $error("select vector must be 12 bits");
        end
    endgenerate

    // whole module state
    typedef struct packed {
        bus_state_t state;
        logic reset_pulse;
        logic grant;
        logic driven;
        logic [2:0] status;
        logic status_oe;
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic write;
        logic [`DATA_W-1:0] ad;
        logic ad_oe;
        logic ale;
        logic rd_n;
        logic wr_n;
        logic dir;
        logic [SEL_W-1:0] hit;
        logic [SEL_W-1:0] sel_n;
        logic latched_addr_bit1;
        logic sixth_pin;
        logic accept;
        logic done;
    } regs_t;

    regs_t s;
    regs_t next_s;

    logic hold_req;
    logic upper_hit;
    logic lower_hit;
    logic [`MID_COUNT-1:0] mid_hit;
    logic [`PERIPH_COUNT-1:0] periph_hit;
    logic boundary;
    logic in_cycle;

    // takeover request crosses into the core clock
    hold_sync u_sync (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .async_i(bus_takeover_req_i),
        .sync_o(hold_req)
    );

    // decode the incoming request address
    select_decode u_decode (
        .addr_i(cycle_addr_i),
        .mem_i(cycle_mem_i),
        .upper_start_i(upper_start_i),
        .lower_last_i(lower_last_i),
        .mid_base_i(mid_base_i),
        .mid_size_sel_i(mid_size_sel_i),
        .periph_base_i(periph_base_i),
        .periph_in_mem_i(periph_in_mem_i),
        .upper_hit_o(upper_hit),
        .lower_hit_o(lower_hit),
        .mid_hit_o(mid_hit),
        .periph_hit_o(periph_hit)
    );

    // cycle boundaries where a new cycle or a grant may begin
    assign boundary = s.state == st_idle || s.state == bus_state_four;

    // next-state logic
    always_comb begin
        next_s = s;
        next_s.reset_pulse = 1'h0;
        next_s.accept = 1'h0;
        next_s.done = 1'h0;
        // status high through reset, floated one clock after
        if (s.reset_pulse) begin
            next_s.status_oe = 1'h0;
        end
        unique case (s.state)
            st_idle: begin
                next_s.state = st_idle;
            end
            bus_state_one: begin
                // address phase ends, data phase begins
                next_s.state = st_two;
                next_s.ale = 1'h0;
                next_s.ad = s.wdata;
                next_s.ad_oe = s.write;
                next_s.rd_n = s.write;
                next_s.wr_n = ~s.write;
            end
            st_two: begin
                next_s.state = st_three;
                next_s.status = `STATUS_PASSIVE;
            end
            st_three: begin
                // strobes end, cycle completes
                next_s.state = bus_state_four;
                next_s.rd_n = 1'h1;
                next_s.wr_n = 1'h1;
                next_s.done = 1'h1;
            end
            bus_state_four: begin
                next_s.state = st_idle;
                next_s.ad_oe = 1'h0;
            end
            st_granted: begin
                // release once the request is seen low
                if (!hold_req) begin
                    next_s.grant = 1'h0;
                    next_s.state = st_idle;
                end
            end
            default: begin
                next_s.state = st_idle;
            end
        endcase

        // hand-over only between cycles; takeover beats a new cycle
        if (boundary && hold_req) begin
            next_s.state = st_granted;
            next_s.grant = 1'h1;
            next_s.driven = 1'h0;
            next_s.status_oe = 1'h0;
            next_s.ad_oe = 1'h0;
        end else if (boundary && cycle_req_i) begin
            // start of a new cycle retakes the bus
            next_s.state = bus_state_one;
            next_s.accept = 1'h1;
            next_s.driven = 1'h1;
            next_s.status_oe = 1'h1;
            next_s.addr = cycle_addr_i;
            next_s.wdata = cycle_wdata_i;
            next_s.write = cycle_write_i;
            // bit 2 memory/io, bit 1 direction
            next_s.status = {cycle_mem_i, cycle_write_i,
                ~cycle_write_i & ~cycle_fetch_i};
            next_s.dir = cycle_write_i;
            next_s.ad = cycle_addr_i[`DATA_W-1:0];
            next_s.ad_oe = 1'h1;
            next_s.ale = 1'h1;
            next_s.rd_n = 1'h1;
            next_s.wr_n = 1'h1;
            next_s.hit = {periph_hit, mid_hit, lower_hit, upper_hit};
            next_s.latched_addr_bit1 = cycle_addr_i[1];
        end
    end

    // selects active only while a cycle is under way
    always_comb begin
        in_cycle = next_s.state == bus_state_one || next_s.state == st_two
            || next_s.state == st_three || next_s.state == bus_state_four;
    end

    // registered select levels and the sixth pin
    regs_t q;
    always_comb begin
        q = next_s;
        q.sel_n = in_cycle ? ~next_s.hit : {SEL_W{`SEL_IDLE_N}};
        // latched bit keeps its value through the grant
        q.sixth_pin = sixth_is_addr1_i ? next_s.latched_addr_bit1
            : q.sel_n[SEL_W-1];
    end

    // state register
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s <= '0;
            s.state <= st_idle;
            s.reset_pulse <= 1'h1;
            s.status <= `STATUS_RESET;
            s.status_oe <= 1'h1;
            s.rd_n <= 1'h1;
            s.wr_n <= 1'h1;
            s.sel_n <= {SEL_W{`SEL_IDLE_N}};
            s.sixth_pin <= 1'h1;
        end else begin
            s <= q;
        end
    end

    // outputs straight from the state register
    assign cycle_accept_o = s.accept;
    assign cycle_done_o = s.done;
    assign bus_takeover_grant_o = s.grant;
    assign cycle_status_bit2_o = s.status[2];
    assign cycle_status_bit1_o = s.status[1];
    assign cycle_status_bit0_o = s.status[0];
    assign cycle_status_oe_o = s.status_oe;
    assign ad_o = s.ad;
    assign addr_hi_o = s.addr[`ADDR_W-1:`DATA_W];
    // ad_oe is only ever set together with driven, so it stands alone
    assign ad_oe_o = s.ad_oe;
    assign addr_latch_o = s.ale;
    assign rd_n_o = s.rd_n;
    assign wr_n_o = s.wr_n;
    assign xcvr_direction_o = s.dir;
    assign ctrl_oe_o = s.driven;

    // selects never float, grant or not
    assign upper_mem_select_n_o = s.sel_n[0];
    assign lower_mem_select_n_o = s.sel_n[1];
    assign mid_mem_selects_n_o = s.sel_n[5:2];
    assign periph_selects_n_o = s.sel_n[10:6];
    assign sixth_select_or_addr_bit1_o = s.sixth_pin;
endmodule // bus_hold_cs

// file: bus_hold_cs_monitor.sv
// assertions on the hand-over, status and select ports of bus_hold_cs
// assumes it is bound into bus_hold_cs; one clock, async active-high reset
`timescale 1ns/1ns
`include "bus_hold_defs.svh"
module bus_hold_cs_monitor (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // core side and configuration
    input wire logic [`ADDR_W-1:0] cycle_addr_i,
    input wire logic cycle_mem_i,
    input wire logic cycle_write_i,
    input wire logic cycle_accept_o,
    input wire logic cycle_done_o,
    input wire logic [7:0] upper_start_i,
    input wire logic [7:0] lower_last_i,
    // takeover, status and bus enables
    input wire logic bus_takeover_req_i,
    input wire logic bus_takeover_grant_o,
    input wire logic cycle_status_bit2_o,
    input wire logic cycle_status_bit1_o,
    input wire logic cycle_status_bit0_o,
    input wire logic cycle_status_oe_o,
    input wire logic ad_oe_o,
    input wire logic ctrl_oe_o,
    input wire logic xcvr_direction_o,
    // selects
    input wire logic upper_mem_select_n_o,
    input wire logic lower_mem_select_n_o,
    input wire logic [`MID_COUNT-1:0] mid_mem_selects_n_o,
    input wire logic [`PERIPH_COUNT-2:0] periph_selects_n_o,
    input wire logic sixth_select_or_addr_bit1_o
);
    // all plain selects inactive
    wire logic sel_idle;
    assign sel_idle = upper_mem_select_n_o & lower_mem_select_n_o
        & (&mid_mem_selects_n_o) & (&periph_selects_n_o);

    // one clock domain
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    chk_reset_status: assert property (disable iff (1'b0)
        reset_i && $past(reset_i) |-> cycle_status_oe_o && !bus_takeover_grant_o && {cycle_status_bit2_o,
        cycle_status_bit1_o, cycle_status_bit0_o} == `STATUS_RESET) else $error("reset status");
    chk_status_float: assert property (
        $fell(reset_i) |=> !cycle_status_oe_o || cycle_accept_o) else $error("status not floated");
    chk_status_kind: assert property (
        cycle_accept_o |-> cycle_status_oe_o && cycle_status_bit2_o == $past(cycle_mem_i)
        && cycle_status_bit1_o == $past(cycle_write_i)
        && xcvr_direction_o == $past(cycle_write_i)) else $error("status kind wrong");
    chk_sync_delay: assert property (
        $rose(bus_takeover_req_i) && !bus_takeover_grant_o |-> !bus_takeover_grant_o [*3])
        else $error("grant before sync");
    chk_grant_point: assert property (
        $rose(bus_takeover_grant_o) |-> !$past(cycle_accept_o, 2) && !$past(cycle_accept_o, 3))
        else $error("grant mid cycle");
    chk_grant_float: assert property (
        bus_takeover_grant_o |-> !ad_oe_o && !ctrl_oe_o && !cycle_status_oe_o && sel_idle)
        else $error("bus driven in grant");
    chk_grant_release: assert property (
        $fell(bus_takeover_req_i) && bus_takeover_grant_o |-> ##[1:3] !bus_takeover_grant_o)
        else $error("grant held");
    chk_resume_drive: assert property (
        $rose(ad_oe_o) || $rose(ctrl_oe_o) |-> cycle_accept_o) else $error("drive without cycle");
    chk_sixth_held: assert property (
        bus_takeover_grant_o && $past(bus_takeover_grant_o) |-> $stable(sixth_select_or_addr_bit1_o))
        else $error("sixth pin moved");
    chk_upper_range: assert property (
        cycle_accept_o |-> upper_mem_select_n_o == !($past(cycle_mem_i)
        && $past(cycle_addr_i[19:10]) >= {2'h3, upper_start_i})) else $error("upper select");
    chk_lower_range: assert property (
        cycle_accept_o |-> lower_mem_select_n_o == !($past(cycle_mem_i)
        && $past(cycle_addr_i[19:10]) <= {2'h0, lower_last_i})) else $error("lower select");
    chk_idle_select: assert property (
        !cycle_accept_o && !$past(cycle_accept_o) && !$past(cycle_accept_o, 2) && !cycle_done_o
        |-> sel_idle) else $error("select outside cycle");
endmodule // bus_hold_cs_monitor

// file: bus_hold_cs_test.sv
// self-checking bench for bus_hold_cs: reset, decode rows, then hand-over and second reset cases
// assumes bus_peer drives the takeover pin and the monitor is bound in
`timescale 1ns/1ns
`include "bus_hold_defs.svh"
module bus_hold_cs_test;
    // design inputs
    logic core_clk_i = 1'b0, reset_i = 1'b1, cycle_req_i = 1'b0, want = 1'b0;
    logic [19:0] cycle_addr_i = 20'h0;
    logic [15:0] cycle_wdata_i = 16'h0;
    logic cycle_mem_i = 1'b0, cycle_write_i = 1'b0, cycle_fetch_i = 1'b0;
    logic [7:0] upper_start_i = 8'hf0, lower_last_i = 8'h0f;
    logic [6:0] mid_base_i = 7'h08;
    logic [2:0] mid_size_sel_i = 3'h3;
    logic [5:0] periph_base_i = 6'h01;
    logic periph_in_mem_i = 1'b0, sixth_is_addr1_i = 1'b0, bus_takeover_req_i;
    // design outputs
    logic cycle_accept_o, cycle_done_o, bus_takeover_grant_o, cycle_status_oe_o;
    logic cycle_status_bit2_o, cycle_status_bit1_o, cycle_status_bit0_o, ad_oe_o, ctrl_oe_o;
    logic [15:0] ad_o;
    logic [3:0] addr_hi_o, mid_mem_selects_n_o;
    logic addr_latch_o, rd_n_o, wr_n_o, xcvr_direction_o;
    logic upper_mem_select_n_o, lower_mem_select_n_o, sixth_select_or_addr_bit1_o;
    logic [4:0] periph_selects_n_o;
    logic [11:0] sel_vec;
    int error_cnt = 0, tests_run = 0, i, n;
    logic seen;
    // rows: address, mem/write/fetch, expected select hits (upper..sixth)
    logic [34:0] rows [12] = '{{20'hfc000, 3'b100, 12'h800}, {20'hfbfff, 3'b110, 12'h000},
        {20'h03fff, 3'b101, 12'h400}, {20'h04000, 3'b100, 12'h000},
        {20'h10000, 3'b110, 12'h040}, {20'h1c000, 3'b100, 12'h200},
        {20'h20000, 3'b100, 12'h000}, {20'h00400, 3'b000, 12'h002},
        {20'h00680, 3'b010, 12'h001}, {20'h00600, 3'b000, 12'h020},
        {20'h00400, 3'b100, 12'h400}, {20'h10400, 3'b000, 12'h000}};

    // select pins gathered as one word
    assign sel_vec = {upper_mem_select_n_o, lower_mem_select_n_o, mid_mem_selects_n_o,
        periph_selects_n_o, sixth_select_or_addr_bit1_o};
    always #5 core_clk_i = ~core_clk_i;
    bus_hold_cs u_bus_hold_cs (.*);
    bus_peer u_bus_peer (.want_i(want), .req_o(bus_takeover_req_i));

    // helpers
    task tick;
        @(posedge core_clk_i);
        #1;
    endtask
    task chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("mismatches %0d comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task bound(input int lim);
        if (n >= lim) begin
            error_cnt++;
            conclude;
        end
    endtask
    task wait_grant(input logic v);
        for (n = 0; n < 8 && bus_takeover_grant_o !== v; n++) tick;
        bound(8);
    endtask
    task run_cycle(input logic [19:0] a, input logic [2:0] k, input logic [11:0] mask);
        @(negedge core_clk_i);
        {cycle_mem_i, cycle_write_i, cycle_fetch_i} = k;
        cycle_addr_i = a;
        cycle_wdata_i = a[15:0];
        cycle_req_i = 1'b1;
        for (n = 0; n < 20 && cycle_accept_o !== 1'b1; n++) tick;
        bound(20);
        chk(sel_vec, ~mask);
        chk({cycle_status_bit2_o, cycle_status_bit1_o, cycle_status_bit0_o, xcvr_direction_o},
            {k[2], k[1], ~k[1] & ~k[0], k[1]});
        chk({ad_oe_o, ctrl_oe_o, cycle_status_oe_o}, 12'h7);
        @(negedge core_clk_i) cycle_req_i = 1'b0;
        for (n = 0; n < 8 && cycle_done_o !== 1'b1; n++) tick;
        bound(8);
        tick;
        chk(sel_vec | {11'h0, sixth_is_addr1_i}, 12'hfff);
    endtask

    // main sequence
    initial begin
        repeat (15) @(negedge core_clk_i);
        chk({bus_takeover_grant_o, cycle_status_oe_o, cycle_status_bit2_o,
            cycle_status_bit1_o, cycle_status_bit0_o}, 12'h0f);
        chk(sel_vec, 12'hfff);
        @(negedge core_clk_i) reset_i = 1'b0;
        tick;
        chk(cycle_status_oe_o, 12'h0);
        for (i = 0; i < 12; i++) run_cycle(rows[i][34:15], rows[i][14:12], rows[i][11:0]);
        // takeover at idle while the core waits for the bus
        @(negedge core_clk_i) want = 1'b1;
        wait_grant(1'b1);
        chk({ad_oe_o, ctrl_oe_o, cycle_status_oe_o}, 12'h0);
        chk(sel_vec, 12'hfff);
        @(negedge core_clk_i) cycle_req_i = 1'b1;
        repeat (4) tick;
        chk({cycle_accept_o, ad_oe_o}, 12'h0);
        @(negedge core_clk_i) want = 1'b0;
        wait_grant(1'b0);
        run_cycle(rows[0][34:15], rows[0][14:12], rows[0][11:0]);
        // takeover raised in the middle of a cycle waits for its end
        @(negedge core_clk_i) cycle_req_i = 1'b1;
        for (n = 0; n < 8 && cycle_accept_o !== 1'b1; n++) tick;
        bound(8);
        @(negedge core_clk_i) cycle_req_i = 1'b0;
        want = 1'b1;
        seen = 1'b0;
        for (n = 0; n < 12 && bus_takeover_grant_o !== 1'b1; n++) begin
            if (cycle_done_o === 1'b1) seen = 1'b1;
            tick;
        end
        chk(seen, 12'h1);
        @(negedge core_clk_i) want = 1'b0;
        wait_grant(1'b0);
        // sixth pin as latched address bit held through a grant
        @(negedge core_clk_i) sixth_is_addr1_i = 1'b1;
        run_cycle(20'h00002, 3'b100, 12'h400);
        run_cycle(20'h00000, 3'b100, 12'h401);
        @(negedge core_clk_i) want = 1'b1;
        wait_grant(1'b1);
        repeat (3) tick;
        chk(sixth_select_or_addr_bit1_o, 12'h0);
        @(negedge core_clk_i) want = 1'b0;
        wait_grant(1'b0);
        // second reset in mid-run: status driven high, then floated again
        @(negedge core_clk_i) reset_i = 1'b1;
        sixth_is_addr1_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        chk({bus_takeover_grant_o, cycle_status_oe_o, cycle_status_bit2_o,
            cycle_status_bit1_o, cycle_status_bit0_o}, 12'h0f);
        chk(sel_vec, 12'hfff);
        @(negedge core_clk_i) reset_i = 1'b0;
        tick;
        chk(cycle_status_oe_o, 12'h0);
        run_cycle(rows[7][34:15], rows[7][14:12], rows[7][11:0]);
        conclude;
    end
endmodule // bus_hold_cs_test

bind bus_hold_cs bus_hold_cs_monitor u_bus_hold_cs_monitor (.*);

// file: bus_hold_defs.svh
// constants for the bus hand-over and select block
// assumes a 20-bit address, 16-bit data and a single core clock
`ifndef BUS_HOLD_DEFS_SVH
`define BUS_HOLD_DEFS_SVH
`define ADDR_W 20
`define DATA_W 16
`define STATUS_PASSIVE 3'h7
`define STATUS_RESET 3'h7
`define SEL_IDLE_N 1'h1
`define MID_SEL_MAX 3'h6
`define PERIPH_COUNT 6
`define MID_COUNT 4
`endif

// file: bus_hold_pkg.sv
// types shared by the bus hand-over and select block
// assumes the constants header is included by each user
`include "bus_hold_defs.svh"
package bus_hold_pkg;
    // bus states; idle and bus_state_four double as the cycle boundaries
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        bus_state_one = 3'h1,
        st_two = 3'h2,
        st_three = 3'h3,
        bus_state_four = 3'h4,
        st_granted = 3'h5
    } bus_state_t;
endpackage

// file: bus_peer.sv
// behavioural model of the other local bus master
// assumes the bench commands it; its request has no phase relation to the clock
`timescale 1ns/1ns
module bus_peer (
    // bench command
    input wire logic want_i,
    // takeover pin
    output logic req_o
);
    // request follows the command with a skew off the clock grid
    initial req_o = 1'b0;
    always @(want_i) begin
        req_o <= #3 want_i; // high for as long as the bus is wanted
    end
endmodule // bus_peer

// file: hold_sync.sv
// two-stage synchroniser for the asynchronous takeover request
// assumes the request pin has no timing relation to core_clk_i
`timescale 1ns/1ns
module hold_sync (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // raw pin and synchronised level
    input wire logic async_i,
    output logic sync_o
);
    logic meta;
    // first stage feeds only the second stage
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meta <= 1'h0;
            sync_o <= 1'h0;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // hold_sync

// file: select_decode.sv
// address decoder for memory and peripheral selects
// assumes configuration inputs are stable on the core clock
`timescale 1ns/1ns
`include "bus_hold_defs.svh"
module select_decode (
    // access under test
    input wire logic [`ADDR_W-1:0] addr_i,
    input wire logic mem_i,
    // range configuration
    input wire logic [7:0] upper_start_i,
    input wire logic [7:0] lower_last_i,
    input wire logic [6:0] mid_base_i,
    input wire logic [2:0] mid_size_sel_i,
    input wire logic [5:0] periph_base_i,
    input wire logic periph_in_mem_i,
    // active-high hits
    output logic upper_hit_o,
    output logic lower_hit_o,
    output logic [`MID_COUNT-1:0] mid_hit_o,
    output logic [`PERIPH_COUNT-1:0] periph_hit_o
);
    logic [6:0] mid_mask;
    logic mid_in;
    logic [1:0] mid_quarter;
    logic periph_in;
    // top and bottom regions in 1K steps up to 256K
    assign upper_hit_o = mem_i && addr_i[19:18] == 2'h3
        && addr_i[17:10] >= upper_start_i;
    assign lower_hit_o = mem_i && addr_i[19:18] == 2'h0
        && addr_i[17:10] <= lower_last_i;
    // mid area of 8K << size, split into four equal blocks
    assign mid_mask = 7'((8'h1 << mid_size_sel_i) - 8'h1);
    assign mid_in = mem_i && mid_size_sel_i <= `MID_SEL_MAX
        && (addr_i[19:13] & ~mid_mask) == (mid_base_i & ~mid_mask);
    assign mid_quarter = addr_i[5'd11 + {2'h0, mid_size_sel_i} +: 2];
    // peripheral area: 128-byte windows inside a 1K block
    assign periph_in = (mem_i == periph_in_mem_i)
        && addr_i[15:10] == periph_base_i
        && (periph_in_mem_i || addr_i[19:16] == 4'h0);
    genvar gi;
    generate
        for (gi = 0; gi < `MID_COUNT; gi++) begin : g_mid
            assign mid_hit_o[gi] = mid_in && mid_quarter == 2'(gi);
        end
        for (gi = 0; gi < `PERIPH_COUNT; gi++) begin : g_per
            assign periph_hit_o[gi] = periph_in && addr_i[9:7] == 3'(gi);
        end
    endgenerate
endmodule // select_decode
